// ### rtl/irq_defines.svh
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH
// Summary of operation
// - Twelve sources are arbitrated, each at one of two priority levels.
// - Pending flags set on their event even when masked; masked flags are ignored.
// - Any one of a source's several flags counts as that source's request.
// - Enabled request waits for instruction end, then a long call to its vector.
// - Return-from-interrupt resumes the instruction that would otherwise have run.
// - Each source has its own enable bit, honoured only while global enable is one.
// - Global enable at bit 7 of the main enable register blocks all sources when zero.
// - Request during a global-enable clear may be taken only before single-cycle instructions.
// - Flag still set after a return re-enters service after one more instruction.
// - Any flag but a level-mode external one, written to one by software, requests and vectors like a hardware flag.
// - External input: trigger type 1 edge, 0 level; polarity 1 high, 0 low.
// - External input samples its selected port pin without disturbing that pin.
// - A 3-bit pin select picks port pin 0 through 7.
// - Edge-mode external flags clear automatically when the call to service starts.
// - Level-mode external flag follows the input's active state directly.
// - Only edge-mode external and timer a/b overflow flags self-clear; level-mode external follows its input; others wait for software.
// - High preempts low; high is never preempted; all sources reset to low.
// - Higher level first, then lowest order number from 0 to 11.
// - Reset vectors to 0x0000; order n vectors to 0x0003 plus eight times n.
// - Requests are sampled every clock; fastest response is 1 detect plus 4 call cycles.
// - Request pending at a return waits for one more instruction before vectoring.
// - Request not above the running level waits for its return plus one instruction.

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define IRQ_OFS_ENABLE 6'h00
`define IRQ_OFS_EXT_ENABLE 6'h04
`define IRQ_OFS_PRIORITY 6'h08
`define IRQ_OFS_EXT_PRIORITY 6'h0c
`define IRQ_OFS_PIN_CONFIG 6'h10
`define IRQ_OFS_TIMER_CONTROL 6'h14
`define IRQ_OFS_PERIPH_FLAGS 6'h18
`define IRQ_OFS_STATUS 6'h1c

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define IRQ_RST_ENABLE 8'h00
`define IRQ_RST_PRIORITY 8'hc0
`define IRQ_RST_PIN_CONFIG 8'h01
`define IRQ_RST_TIMER_CONTROL 8'h00
`define IRQ_RST_VECTOR 16'h0000

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define IRQ_GLOBAL_EN_BIT 7
`define IRQ_TC_EXT0_TRIG 0
`define IRQ_TC_EXT0_PEND 1
`define IRQ_TC_EXT1_TRIG 2
`define IRQ_TC_EXT1_PEND 3
`define IRQ_TC_TIMER_A 5
`define IRQ_TC_TIMER_B 7
`define IRQ_CFG_EXT0_SEL 0
`define IRQ_CFG_EXT0_POL 3
`define IRQ_CFG_EXT1_SEL 4
`define IRQ_CFG_EXT1_POL 7

// -----------------------------------------------------------------
// Vectors and counts
// -----------------------------------------------------------------
`define IRQ_VECTOR_BASE 16'h0003
`define IRQ_VECTOR_STEP_SHIFT 3
`define IRQ_NUM_SOURCES 12
`define IRQ_NUM_PFLAGS 13
`endif

// ### rtl/irq_pkg.sv
package irq_pkg;
  typedef logic [11:0] src_vec_t;
  typedef logic [3:0] src_idx_t;
  typedef struct packed {
    logic timer_c_high_overflow;
    logic timer_c_low_overflow;
    logic comparator_rise_event;
    logic comparator_fall_event;
    logic [2:0] counter_array_match;
    logic counter_array_overflow;
    logic converter_done;
    logic converter_window_hit;
    logic smbus_event;
    logic serial_tx_done;
    logic serial_rx_done;
  } periph_evt_t;
  typedef struct packed {
    logic timer_a_overflow;
    logic timer_b_overflow;
  } timer_evt_t;
endpackage

// ### rtl/two_level_interrupt_handler.sv
`timescale 1ns/1ns
`include "irq_defines.svh"
module two_level_interrupt_handler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port_pins,
  input wire irq_pkg::periph_evt_t periph_evt,
  input wire irq_pkg::timer_evt_t timer_evt,
  input wire logic instr_end,
  input wire logic return_from_interrupt_end,
  output logic call_req,
  output logic [15:0] call_addr
);
  import irq_pkg::*;

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic src_idx_t first_set(input src_vec_t v);
    src_idx_t r;
    r = 4'hf;
    for (int i = `IRQ_NUM_SOURCES - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = src_idx_t'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] vector_of(input src_idx_t idx);
    return `IRQ_VECTOR_BASE + {9'h000, idx, 3'h0};
  endfunction

  // -----------------------------------------------------------------
  // Register bus
  // -----------------------------------------------------------------
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [7:0] irq_enable_reg_q;
  logic [7:0] extended_enable_reg_q;
  logic [7:0] irq_priority_reg_q;
  logic [7:0] extended_priority_reg_q;
  logic [7:0] ext_pin_config_reg_q;
  logic [1:0] trig_q;
  logic [1:0] ext_edge_q;
  logic [1:0] ext_prev_q;
  logic timer_a_q;
  logic timer_b_q;
  logic [`IRQ_NUM_PFLAGS-1:0] pflag_q;
  logic req_q;
  logic win_hi_q;
  src_idx_t win_idx_q;
  logic act_hi_q;
  logic act_lo_q;
  logic hold_q;
  logic call_req_q;
  logic [15:0] call_addr_q;

  logic acc;
  logic wr;
  logic [5:0] ofs;
  logic mapped;
  logic [7:0] wd;
  logic take;
  logic [1:0] ext_active;
  logic [1:0] ext_pend;
  logic [7:0] timer_control;
  logic [31:0] rd_mux;
  src_vec_t pend;
  src_vec_t en;
  src_vec_t prio;
  src_vec_t hi_req;
  src_vec_t lo_req;
  logic ea;

  assign acc = psel && penable && pready_q;
  assign wr = acc && pwrite;
  assign ofs = paddr[5:0];
  assign wd = pwdata[7:0];
  assign mapped = (paddr[31:5] == 27'h0) && (ofs[1:0] == 2'b00);

  always_comb begin
    rd_mux = 32'h0;
    unique case (ofs)
      `IRQ_OFS_ENABLE: rd_mux = {24'h0, irq_enable_reg_q};
      `IRQ_OFS_EXT_ENABLE: rd_mux = {24'h0, extended_enable_reg_q};
      `IRQ_OFS_PRIORITY: rd_mux = {24'h0, irq_priority_reg_q};
      `IRQ_OFS_EXT_PRIORITY: rd_mux = {24'h0, extended_priority_reg_q};
      `IRQ_OFS_PIN_CONFIG: rd_mux = {24'h0, ext_pin_config_reg_q};
      `IRQ_OFS_TIMER_CONTROL: rd_mux = {24'h0, timer_control};
      `IRQ_OFS_PERIPH_FLAGS: rd_mux = {19'h0, pflag_q};
      `IRQ_OFS_STATUS: rd_mux = {22'h0, hold_q, act_hi_q, act_lo_q, req_q, win_hi_q, 1'b0, win_idx_q};
      default: rd_mux = 32'h0;
    endcase
  end

  // Access phase always takes one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !mapped;
      if (psel && penable && !pready_q) begin
        prdata_q <= mapped ? rd_mux : 32'h0;
      end
    end
  end

  // Unused bits of the priority registers read as one, of the extended enable as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_reg_q <= `IRQ_RST_ENABLE;
      extended_enable_reg_q <= `IRQ_RST_ENABLE;
      irq_priority_reg_q <= `IRQ_RST_PRIORITY;
      extended_priority_reg_q <= `IRQ_RST_PRIORITY;
      ext_pin_config_reg_q <= `IRQ_RST_PIN_CONFIG;
      trig_q <= 2'b00;
    end else if (wr && mapped) begin
      unique case (ofs)
        `IRQ_OFS_ENABLE: irq_enable_reg_q <= wd;
        `IRQ_OFS_EXT_ENABLE: extended_enable_reg_q <= {2'b00, wd[5:0]};
        `IRQ_OFS_PRIORITY: irq_priority_reg_q <= {2'b11, wd[5:0]};
        `IRQ_OFS_EXT_PRIORITY: extended_priority_reg_q <= {2'b11, wd[5:0]};
        `IRQ_OFS_PIN_CONFIG: ext_pin_config_reg_q <= wd;
        `IRQ_OFS_TIMER_CONTROL: trig_q <= {wd[`IRQ_TC_EXT1_TRIG], wd[`IRQ_TC_EXT0_TRIG]};
        default: ;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // External inputs
  // -----------------------------------------------------------------
  logic wr_tc;
  assign wr_tc = wr && mapped && (ofs == `IRQ_OFS_TIMER_CONTROL);

  generate
    for (genvar g = 0; g < 2; g++) begin : g_ext
      localparam int SEL = g ? `IRQ_CFG_EXT1_SEL : `IRQ_CFG_EXT0_SEL;
      localparam int POL = g ? `IRQ_CFG_EXT1_POL : `IRQ_CFG_EXT0_POL;
      localparam int PND = g ? `IRQ_TC_EXT1_PEND : `IRQ_TC_EXT0_PEND;
      localparam int TRG = g ? `IRQ_TC_EXT1_TRIG : `IRQ_TC_EXT0_TRIG;
      localparam src_idx_t IDX = g ? 4'h2 : 4'h0;
      logic [2:0] sel;
      logic rise;
      logic clr;
      logic trig_now;
      assign sel = ext_pin_config_reg_q[SEL+2:SEL];
      // Mode and flag written together: the new mode decides
      assign trig_now = wr_tc ? wd[TRG] : trig_q[g];
      // Read-only tap of the pin; other pin users unaffected
      assign ext_active[g] = ~(port_pins[sel] ^ ext_pin_config_reg_q[POL]);
      assign rise = ext_active[g] && !ext_prev_q[g];
      assign clr = take && (win_idx_q == IDX);
      assign ext_pend[g] = trig_q[g] ? ext_edge_q[g] : ext_active[g];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ext_prev_q[g] <= 1'b0;
          ext_edge_q[g] <= 1'b0;
        end else begin
          ext_prev_q[g] <= ext_active[g];
          if (!trig_now) begin
            ext_edge_q[g] <= 1'b0;
          end else if (rise || (wr_tc && wd[PND])) begin
            ext_edge_q[g] <= 1'b1;
          end else if (clr || wr_tc) begin
            ext_edge_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // Pending flags
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_a_q <= 1'b0;
      timer_b_q <= 1'b0;
    end else begin
      if (timer_evt.timer_a_overflow || (wr_tc && wd[`IRQ_TC_TIMER_A])) begin
        timer_a_q <= 1'b1;
      end else if ((take && win_idx_q == 4'h1) || wr_tc) begin
        timer_a_q <= 1'b0;
      end
      if (timer_evt.timer_b_overflow || (wr_tc && wd[`IRQ_TC_TIMER_B])) begin
        timer_b_q <= 1'b1;
      end else if ((take && win_idx_q == 4'h3) || wr_tc) begin
        timer_b_q <= 1'b0;
      end
    end
  end

  // Sticky until software writes zero; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pflag_q <= '0;
    end else if (wr && mapped && ofs == `IRQ_OFS_PERIPH_FLAGS) begin
      pflag_q <= pwdata[`IRQ_NUM_PFLAGS-1:0] | periph_evt;
    end else begin
      pflag_q <= pflag_q | periph_evt;
    end
  end

  always_comb begin
    timer_control = 8'h00;
    timer_control[`IRQ_TC_EXT0_TRIG] = trig_q[0];
    timer_control[`IRQ_TC_EXT0_PEND] = ext_pend[0];
    timer_control[`IRQ_TC_EXT1_TRIG] = trig_q[1];
    timer_control[`IRQ_TC_EXT1_PEND] = ext_pend[1];
    timer_control[`IRQ_TC_TIMER_A] = timer_a_q;
    timer_control[`IRQ_TC_TIMER_B] = timer_b_q;
  end

  // -----------------------------------------------------------------
  // Arbitration
  // -----------------------------------------------------------------
  assign pend = {pflag_q[10], pflag_q[9], |pflag_q[8:5], pflag_q[4], pflag_q[3], pflag_q[2],
                 |pflag_q[12:11], |pflag_q[1:0], timer_b_q, ext_pend[1], timer_a_q, ext_pend[0]};
  assign ea = irq_enable_reg_q[`IRQ_GLOBAL_EN_BIT];
  assign en = {extended_enable_reg_q[5:0], irq_enable_reg_q[5:0]} & {`IRQ_NUM_SOURCES{ea}};
  assign prio = {extended_priority_reg_q[5:0], irq_priority_reg_q[5:0]};
  // High is blocked only by a high routine; low by any routine
  assign hi_req = pend & en & prio & {`IRQ_NUM_SOURCES{!act_hi_q}};
  assign lo_req = pend & en & ~prio & {`IRQ_NUM_SOURCES{!act_hi_q && !act_lo_q}};

  // Detect stage: decision uses state one clock old, so a global clear
  // written now still lets a single-cycle next instruction be interrupted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= 1'b0;
      win_hi_q <= 1'b0;
      win_idx_q <= 4'h0;
    end else begin
      req_q <= (|hi_req || |lo_req) && !take;
      win_hi_q <= |hi_req;
      win_idx_q <= |hi_req ? first_set(hi_req) : first_set(lo_req);
    end
  end

  // -----------------------------------------------------------------
  // Vectoring and nesting
  // -----------------------------------------------------------------
  assign take = instr_end && req_q && !hold_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 1'b0;
    end else if (return_from_interrupt_end) begin
      hold_q <= 1'b1;
    end else if (instr_end) begin
      hold_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_hi_q <= 1'b0;
      act_lo_q <= 1'b0;
    end else if (take) begin
      if (win_hi_q) begin
        act_hi_q <= 1'b1;
      end else begin
        act_lo_q <= 1'b1;
      end
    end else if (return_from_interrupt_end) begin
      if (act_hi_q) begin
        act_hi_q <= 1'b0;
      end else begin
        act_lo_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      call_req_q <= 1'b0;
      call_addr_q <= `IRQ_RST_VECTOR;
    end else begin
      call_req_q <= take;
      if (take) begin
        call_addr_q <= vector_of(win_idx_q);
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign call_req = call_req_q;
  assign call_addr = call_addr_q;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  call_vector_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    take |=> call_req_q && (call_addr_q == 16'h0003 + {9'h000, $past(win_idx_q), 3'h0}))
    else $error("call address does not match winning source");
  global_block_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ea |-> ##2 !call_req_q)
    else $error("call issued with global enable clear");
  high_nopreempt_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    act_hi_q |-> ##2 !call_req_q)
    else $error("high routine was preempted");
  return_from_interrupt_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    return_from_interrupt_end ##1 (instr_end or (!instr_end ##1 instr_end)) |=> !call_req_q)
    else $error("vectored without one instruction after return");
  high_first_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (|hi_req && |lo_req) |=> win_hi_q && prio[win_idx_q])
    else $error("low source won over high");
  edge_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    take && win_idx_q == 4'h0 && trig_q[0] && ext_prev_q[0] |=> !ext_edge_q[0])
    else $error("edge flag not cleared on vectoring");
  masked_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    periph_evt.comparator_rise_event |=> pflag_q[10] [*2])
    else $error("peripheral flag lost");
  level_track_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !trig_q[1] && !ext_active[1] |-> !timer_control[`IRQ_TC_EXT1_PEND])
    else $error("level flag set with inactive input");
  apb_ready_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("ready not a single cycle after one wait state");
endmodule

// ### verification/instr_sequencer_model.sv
`timescale 1ns/1ns
module instr_sequencer_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic call_req,
  input wire logic slow,
  input wire logic return_from_interrupt_cmd,
  output logic instr_end,
  output logic return_from_interrupt_end
);
  logic [2:0] gap_q;
  logic return_from_interrupt_q;
  // --------------------------
  // Instruction stream
  // --------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 3'h0;
      return_from_interrupt_q <= 1'b0;
      instr_end <= 1'b0;
      return_from_interrupt_end <= 1'b0;
    end else begin
      instr_end <= 1'b0;
      return_from_interrupt_end <= 1'b0;
      if (return_from_interrupt_cmd) begin
        return_from_interrupt_q <= 1'b1;
      end
      if (call_req) begin
        gap_q <= 3'h4;
      end else if (gap_q != 3'h0) begin
        gap_q <= gap_q - 3'h1;
      end else if (return_from_interrupt_q) begin
        return_from_interrupt_end <= 1'b1;
        return_from_interrupt_q <= 1'b0;
        gap_q <= 3'h1;
      end else begin
        instr_end <= 1'b1;
        gap_q <= slow ? 3'h3 : 3'h1;
      end
    end
  end
endmodule

// ### verification/two_level_interrupt_handler_test.sv
`timescale 1ns/1ns
module two_level_interrupt_handler_test;
  import irq_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic slow = 1'b0, return_from_interrupt_cmd = 1'b0, pready, pslverr, instr_end, return_from_interrupt_end, call_req, rerr;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdat;
  logic [7:0] port_pins = 8'hff;
  logic [15:0] call_addr, got;
  logic [15:0] calls[$];
  periph_evt_t periph_evt = '0;
  timer_evt_t timer_evt = '0;
  int errors = 0, check_count = 0, seed = 97912, pend, pri, pf, redo, late, pins, sel;
  int reg_a[8] = '{0, 4, 8, 'hc, 'h10, 'h14, 'h18, 'h20};
  int reg_x[8] = '{0, 0, 'hc0, 'hc0, 1, 0, 0, 0};
  // --------------------------
  // Design and partner
  // --------------------------
  two_level_interrupt_handler two_level_interrupt_handler_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_pins(port_pins), .periph_evt(periph_evt), .timer_evt(timer_evt),
    .instr_end(instr_end), .return_from_interrupt_end(return_from_interrupt_end), .call_req(call_req), .call_addr(call_addr)
  );
  instr_sequencer_model instr_sequencer_model_i (
    .pclk(pclk), .presetn(presetn), .call_req(call_req), .slow(slow), .return_from_interrupt_cmd(return_from_interrupt_cmd),
    .instr_end(instr_end), .return_from_interrupt_end(return_from_interrupt_end)
  );
  initial begin
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (call_req === 1'b1) begin
      calls.push_back(call_addr);
    end
  end
  initial begin
    repeat (60000) @(posedge pclk);
    fail("watchdog");
  end
  // --------------------------
  // Bus and check tasks
  // --------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic fail(string n);
    errors++;
    $display("mismatch %s expected response seen timeout", n);
    wrap_up();
  endtask
  task automatic chk_reg(string n, logic [31:0] x, logic [31:0] g);
    check_count++;
    if (g !== x) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_vec(string n, logic [15:0] x, logic [15:0] g);
    check_count++;
    if (g !== x) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic done(string n);
    $display("test %s finished", n);
  endtask
  task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail("pready");
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic take();
    int n;
    n = 0;
    while (calls.size() == 0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (calls.size() == 0) begin
      fail("call_req");
    end
    got = calls.pop_front();
  endtask
  task automatic ret();
    int n;
    n = 0;
    return_from_interrupt_cmd <= 1'b1;
    @(posedge pclk);
    return_from_interrupt_cmd <= 1'b0;
    do begin
      @(posedge pclk);
      n++;
    end while (return_from_interrupt_end !== 1'b1 && n < 40);
    if (n >= 40) begin
      fail("return_from_interrupt_end");
    end
  endtask
  // --------------------------
  // Reference model
  // --------------------------
  function automatic int pick(int lvl);
    for (int h = 1; h > lvl; h--) begin
      for (int s = 0; s < 12; s++) begin
        if (pend[s] && pri[s] == h) begin
          return s;
        end
      end
    end
    return -1;
  endfunction
  function automatic int pmask(int s);
    case (s)
      4: return 'h3;
      5: return 'h1800;
      6: return 'h4;
      7: return 'h8;
      8: return 'h10;
      9: return 'h1e0;
      10: return 'h200;
      11: return 'h400;
      default: return 0;
    endcase
  endfunction
  task automatic serve(int lvl);
    int s;
    s = pick(lvl);
    take();
    chk_vec("vector", 16'h0003 + 16'(8 * s), got);
    if (s == redo) begin
      redo = -1;
    end else begin
      pend[s] = 0;
      if (s > 3) begin
        pf &= ~pmask(s);
        if (late && pri[s] == 0) begin
          late = 0;
          pend[6] = 1;
          pf |= 'h4;
        end
        apb(1'b1, 32'h18, pf);
      end
    end
    while (pick(pri[s]) >= 0) begin
      serve(pri[s]);
    end
    ret();
  endtask
  // --------------------------
  // Stimulus
  // --------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, reg_a[i], 32'h0);
      chk_reg("reset value", reg_x[i], rdat);
      chk_reg("slave error", i == 7, rerr);
    end
    done("reset values");
    periph_evt.converter_done <= 1'b1;
    periph_evt.comparator_rise_event <= 1'b1;
    timer_evt.timer_b_overflow <= 1'b1;
    @(posedge pclk);
    periph_evt <= '0;
    timer_evt <= '0;
    apb(1'b0, 32'h18, 32'h0);
    chk_reg("periph flags", 32'h410, rdat);
    apb(1'b1, 32'h14, 32'haf);
    pf = 'h1ffb;
    apb(1'b1, 32'h18, pf);
    apb(1'b1, 32'h04, 32'h3f);
    apb(1'b1, 32'h00, 32'h3f);
    repeat (30) @(posedge pclk);
    chk_reg("masked calls", 0, calls.size());
    done("masked");
    pri = (($random(seed) & 'hfff) | 'h40) & ~'h100;
    apb(1'b1, 32'h08, pri & 'h3f);
    apb(1'b1, 32'h0c, pri >> 6);
    apb(1'b0, 32'h0c, 32'h0);
    chk_reg("ext priority", 32'hc0 | (pri >> 6), rdat);
    pend = 'hfbf;
    redo = 8;
    late = 1;
    apb(1'b1, 32'h00, 32'hbf);
    while (pick(-1) >= 0) begin
      slow <= 1'($random(seed));
      serve(-1);
    end
    repeat (30) @(posedge pclk);
    chk_reg("spare calls", 0, calls.size());
    done("arbitration");
    for (int m = 0; m < 4; m++) begin
      sel = $random(seed) & 7;
      pins = $random(seed);
      pins[sel] = ~m[1];
      apb(1'b1, 32'h00, 32'h0);
      port_pins <= pins[7:0];
      apb(1'b1, 32'h10, m[1] * 8 + sel);
      apb(1'b1, 32'h14, m[0]);
      apb(1'b1, 32'h00, 32'h81);
      port_pins[sel] <= m[1];
      repeat (2) @(posedge pclk);
      if (m[0]) begin
        port_pins[sel] <= ~m[1];
      end
      take();
      chk_vec("ext vector", 16'h0003, got);
      apb(1'b0, 32'h14, 32'h0);
      chk_reg("ext pending", (m[0] ? 32'h1 : 32'h2) | (port_pins[0] ? 32'h0 : 32'h8), rdat);
      port_pins[sel] <= ~m[1];
      ret();
      repeat (20) @(posedge pclk);
      chk_reg("ext repeat", 0, calls.size());
    end
    done("external");
    wrap_up();
  end
endmodule
